// ===== rtl/apch_defines.vh
`ifndef APCH_DEFINES_VH
`define APCH_DEFINES_VH
`define APCH_DELIM      8'h7E
`define APCH_ESC        8'h7D
`define APCH_XON        8'h11
`define APCH_XOFF       8'h13
`define APCH_ESC_XOR    8'h20
`define APCH_CKS_GOOD   8'hFF
`define APCH_T_IMM      8'h08
`define APCH_T_QUEUE    8'h09
`define APCH_T_RESP     8'h88
`define APCH_ID_SILENT  8'h00
`define APCH_ST_OK      8'h00
`define APCH_ST_ERR     8'h01
`define APCH_CMD_APPLY  16'h4143
`define APCH_HDR_LEN    16'h0004
`define APCH_RLEN_NODAT 8'h05
`define APCH_RLEN_DATA  8'h06
`define APCH_ONE16      16'h0001
`endif

// ===== rtl/apch_param_table.v
`timescale 1ns/1ps
`include "apch_defines.vh"
// ---------------------------------------------------------------
// active and pending parameter storage
// ---------------------------------------------------------------
module apch_param_table #(
   parameter N_PARAM = 4,
   parameter IW      = 2
) (
   // clock and reset
   input  wire            sys_clk,
   input  wire            reset,
   // access
   input  wire [IW-1:0]   idx,
   input  wire [7:0]      wdata,
   input  wire            wr_active,
   input  wire            wr_pending,
   input  wire            commit,
   output wire [7:0]      rdata,
   // active values, flattened
   output wire [8*N_PARAM-1:0] active_flat
);
   reg [7:0] act_r  [0:N_PARAM-1];
   reg [7:0] pend_r [0:N_PARAM-1];
   reg       pv_r   [0:N_PARAM-1];
   genvar g;
   generate
      for (g = 0; g < N_PARAM; g = g + 1)
      begin : g_p
         always @(posedge sys_clk)
         begin
            if (reset)
            begin
               act_r[g]  <= 8'h00;
               pend_r[g] <= 8'h00;
               pv_r[g]   <= 1'b0;
            end
            else
            begin
               // a direct write in the same cycle wins over a stale commit
               if (wr_active && idx == g)
                  act_r[g] <= wdata;
               else if (commit && pv_r[g])
                  act_r[g] <= pend_r[g];
               if (wr_pending && idx == g)
               begin
                  pend_r[g] <= wdata;
                  pv_r[g]   <= 1'b1;
               end
               else if (commit)
                  pv_r[g] <= 1'b0;
            end
         end
         assign active_flat[8*g+7:8*g] = act_r[g];
      end
   endgenerate
   assign rdata = act_r[idx];
endmodule // apch_param_table

// ===== rtl/apch_handler.v
`timescale 1ns/1ps
`include "apch_defines.vh"
// ---------------------------------------------------------------
// parameter command frame handler
// ---------------------------------------------------------------
module apch_handler #(
   parameter N_PARAM = 4,
   parameter IW      = 2
) (
   // clock and reset
   input  wire                 sys_clk,
   input  wire                 reset,
   // receive byte stream
   input  wire [7:0]           rx_data,
   input  wire                 rx_valid,
   // transmit byte stream
   output reg  [7:0]           tx_data,
   output reg                  tx_valid,
   input  wire                 tx_ready,
   // mode and parameters
   input  wire                 api_framing_mode_setting,
   input  wire [16*N_PARAM-1:0] cmd_names,
   output reg  [8*N_PARAM-1:0] param_active,
   output reg                  frame_error
);
   localparam S_IDLE = 3'b000, S_LH = 3'b001, S_LL = 3'b010, S_DATA = 3'b011;
   localparam S_CKS  = 3'b100, S_EXEC = 3'b101, S_TX = 3'b110;

   reg  [2:0]  st_r;
   reg  [15:0] len_r, cnt_r;
   reg  [7:0]  sum_r, type_r, id_r, c0_r, c1_r, val_r, stat_r, rd_r, tsum_r;
   reg         esc_r, hasv_r;
   reg  [2:0]  ti_r;
   reg         tesc_r;
   reg  [IW-1:0] idx_r;
   reg         hit_r;
   wire [7:0]  rdata;
   wire [8*N_PARAM-1:0] act_flat;
   reg         wr_a, wr_p, commit;

   // escape decode: unescaped data may hold the delimiter value, so there only idle sees a start
   wire        raw_delim = rx_valid && rx_data == `APCH_DELIM && (api_framing_mode_setting || st_r == S_IDLE);
   wire        is_esc    = api_framing_mode_setting && rx_data == `APCH_ESC;
   wire [7:0]  rxb       = esc_r ? (rx_data ^ `APCH_ESC_XOR) : rx_data;
   wire        bv        = rx_valid && !raw_delim && !(is_esc && !esc_r);

   function needs_esc;
      input [7:0] b;
      needs_esc = b == `APCH_DELIM || b == `APCH_ESC || b == `APCH_XON || b == `APCH_XOFF;
   endfunction

   integer k;
   always @*
   begin
      idx_r = {IW{1'b0}};
      hit_r = 1'b0;
      for (k = 0; k < N_PARAM; k = k + 1)
         if (cmd_names[16*k +: 16] == {c0_r, c1_r})
         begin
            idx_r = k[IW-1:0];
            hit_r = 1'b1;
         end
   end

   wire is_imm   = type_r == `APCH_T_IMM;
   wire is_apply = {c0_r, c1_r} == `APCH_CMD_APPLY;
   always @*
   begin
      wr_a   = (st_r == S_EXEC) && hit_r && hasv_r && is_imm;
      wr_p   = (st_r == S_EXEC) && hit_r && hasv_r && !is_imm;
      commit = (st_r == S_EXEC) && (is_imm || is_apply);
   end

   apch_param_table #(.N_PARAM(N_PARAM), .IW(IW)) u_tab (
      .sys_clk     (sys_clk),
      .reset       (reset),
      .idx         (idx_r),
      .wdata       (val_r),
      .wr_active   (wr_a),
      .wr_pending  (wr_p),
      .commit      (commit),
      .rdata       (rdata),
      .active_flat (act_flat)
   );

   // response byte for index: delim, len hi, len lo, type, id, c0, c1, status; data and cks come from the tail
   reg [7:0] tb;
   always @*
   begin
      case (ti_r)
         3'd0:    tb = `APCH_DELIM;
         3'd1:    tb = 8'h00;
         3'd2:    tb = (hasv_r || !hit_r) ? `APCH_RLEN_NODAT : `APCH_RLEN_DATA;
         3'd3:    tb = `APCH_T_RESP;
         3'd4:    tb = id_r;
         3'd5:    tb = c0_r;
         3'd6:    tb = c1_r;
         default: tb = stat_r;
      endcase
   end
   wire last_hdr = ti_r == 3'd7;

   // ---------------------------------------------------------------
   // frame state machine
   // ---------------------------------------------------------------
   reg [1:0] tail_r;  // 0 status, 1 read data, 2 checksum, 3 done
   wire [7:0] cur = (tail_r == 2'd0) ? tb : (tail_r == 2'd1 ? rd_r : (`APCH_CKS_GOOD - tsum_r));
   always @(posedge sys_clk)
   begin
      if (reset)
      begin
         st_r <= S_IDLE; len_r <= 16'h0000; cnt_r <= 16'h0000; sum_r <= 8'h00;
         type_r <= 8'h00; id_r <= 8'h00; c0_r <= 8'h00; c1_r <= 8'h00; val_r <= 8'h00;
         stat_r <= 8'h00; rd_r <= 8'h00; tsum_r <= 8'h00; esc_r <= 1'b0; hasv_r <= 1'b0;
         ti_r <= 3'd0; tesc_r <= 1'b0; tail_r <= 2'd0; tx_data <= 8'h00; tx_valid <= 1'b0;
         param_active <= {8*N_PARAM{1'b0}}; frame_error <= 1'b0;
      end
      else
      begin
         param_active <= act_flat;
         frame_error  <= 1'b0;
         // read data is taken during send so a commit by the same frame is already visible
         if (st_r == S_TX)
            rd_r <= rdata;
         if (rx_valid && st_r != S_EXEC && st_r != S_TX)
            esc_r <= is_esc && !esc_r && !raw_delim;
         if (raw_delim && st_r != S_EXEC && st_r != S_TX)
            st_r <= S_LH;
         else
         begin
            case (st_r)
               S_IDLE: ;
               S_LH:   if (bv) begin len_r[15:8] <= rxb; st_r <= S_LL; end
               S_LL:   if (bv)
                       begin
                          len_r[7:0] <= rxb; cnt_r <= 16'h0000; sum_r <= 8'h00; hasv_r <= 1'b0;
                          st_r <= S_DATA;
                       end
               S_DATA: if (bv)
                       begin
                          sum_r <= sum_r + rxb;
                          case (cnt_r)
                             16'h0000: type_r <= rxb;
                             16'h0001: id_r   <= rxb;
                             16'h0002: c0_r   <= rxb;
                             16'h0003: c1_r   <= rxb;
                             `APCH_HDR_LEN: begin val_r <= rxb; hasv_r <= 1'b1; end
                             default: ;  // further value bytes only feed the checksum
                          endcase
                          cnt_r <= cnt_r + `APCH_ONE16;
                          // greater-or-equal so a zero length cannot hang the parser
                          if (cnt_r + `APCH_ONE16 >= len_r)
                             st_r <= S_CKS;
                       end
               S_CKS:  if (bv)
                       begin
                          // bad checksum, short frame or foreign type is dropped without response; only a bad checksum pulses frame_error
                          if (sum_r + rxb == `APCH_CKS_GOOD && len_r >= `APCH_HDR_LEN
                              && (type_r == `APCH_T_IMM || type_r == `APCH_T_QUEUE))
                             st_r <= S_EXEC;
                          else
                          begin
                             frame_error <= sum_r + rxb != `APCH_CKS_GOOD;
                             st_r <= S_IDLE;
                          end
                       end
               S_EXEC: begin
                          stat_r <= (hit_r || is_apply) ? `APCH_ST_OK : `APCH_ST_ERR;
                          ti_r <= 3'd0; tail_r <= 2'd0; tsum_r <= 8'h00; tesc_r <= 1'b0;
                          st_r <= (id_r == `APCH_ID_SILENT) ? S_IDLE : S_TX;
                       end
               S_TX:   if (!tx_valid || tx_ready)
                       begin
                          tx_valid <= 1'b1;
                          if (api_framing_mode_setting && ti_r != 3'd0 && needs_esc(cur) && !tesc_r)
                          begin
                             tx_data <= `APCH_ESC; tesc_r <= 1'b1;
                          end
                          else
                          begin
                             tx_data <= (tesc_r ? cur ^ `APCH_ESC_XOR : cur);
                             tesc_r <= 1'b0;
                             if (ti_r >= 3'd3 && tail_r != 2'd2)
                                tsum_r <= tsum_r + cur;
                             if (!last_hdr)
                                ti_r <= ti_r + 3'd1;
                             else if (tail_r == 2'd0)
                                tail_r <= (hasv_r || !hit_r) ? 2'd2 : 2'd1;
                             else if (tail_r == 2'd1)
                                tail_r <= 2'd2;
                             else
                             begin
                                tail_r <= 2'd3; st_r <= S_IDLE;
                             end
                          end
                       end
               default: st_r <= S_IDLE;
            endcase
         end
         if (tx_valid && tx_ready && st_r != S_TX)
            tx_valid <= 1'b0;
      end
   end
endmodule // apch_handler

// ===== test/apch_handler_sva.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port checker for the parameter command handler
// ---------------------------------------------------------------
module apch_handler_sva #(
   parameter N_PARAM = 4
) (
   input wire                 sys_clk,
   input wire                 reset,
   input wire [7:0]           rx_data,
   input wire                 rx_valid,
   input wire [7:0]           tx_data,
   input wire                 tx_valid,
   input wire                 tx_ready,
   input wire                 api_framing_mode_setting,
   input wire [16*N_PARAM-1:0] cmd_names,
   input wire [8*N_PARAM-1:0] param_active,
   input wire                 frame_error
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("tx byte changed before accept");
   chk_err_pulse: assert property (frame_error |=> !frame_error)
      else $error("frame error longer than one cycle");
   chk_err_silent: assert property (frame_error |=> !tx_valid [*4])
      else $error("response after bad checksum");
   chk_err_cause: assert property (frame_error |-> $past(rx_valid) || $past(rx_valid, 2))
      else $error("frame error without received byte");
   chk_rst_quiet: assert property (disable iff (1'b0) reset |=> !tx_valid && !frame_error && param_active == '0)
      else $error("outputs not cleared by reset");
   chk_act_cause: assert property (!$stable(param_active) |-> $past(rx_valid, 2) || $past(rx_valid, 3)
      || $past(rx_valid, 4))
      else $error("active value changed without a frame");
   chk_tx_start: assert property (api_framing_mode_setting && $rose(tx_valid) && tx_data == 8'h7E
      |-> $past(rx_valid, 2) || $past(rx_valid, 3) || $past(rx_valid, 4))
      else $error("response start not tied to frame end");
   chk_esc_flow: assert property (api_framing_mode_setting && tx_valid |-> tx_data != 8'h11 && tx_data != 8'h13)
      else $error("flow control byte sent unescaped");
endmodule // apch_handler_sva
bind apch_handler apch_handler_sva #(.N_PARAM(N_PARAM)) u_apch_handler_sva (.sys_clk(sys_clk), .reset(reset),
   .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
   .api_framing_mode_setting(api_framing_mode_setting), .cmd_names(cmd_names), .param_active(param_active),
   .frame_error(frame_error));

// ===== test/apch_host.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// host controller model
// ---------------------------------------------------------------
module apch_host (
   // clock
   input  wire       sys_clk,
   // frame link
   output reg  [7:0] rx_data,
   output reg        rx_valid,
   input  wire [7:0] tx_data,
   input  wire       tx_valid,
   output reg        tx_ready,
   // mode
   input  wire       esc
);
   logic [7:0] rq[$];
   logic       unesc_r = 1'b0;
   initial
   begin
      rx_data  = 8'h00;
      rx_valid = 1'b0;
      tx_ready = 1'b0;
   end
   // sink stalls at random so the held byte is exercised
   always @(posedge sys_clk)
   begin
      if (tx_valid && tx_ready)
      begin
         if (esc && !unesc_r && tx_data == 8'h7D) unesc_r <= 1'b1;
         else
         begin
            rq.push_back(unesc_r ? tx_data ^ 8'h20 : tx_data);
            unesc_r <= 1'b0;
         end
      end
      tx_ready <= ($urandom % 3) != 0;
   end
   task put(input logic [7:0] b);
      @(posedge sys_clk);
      rx_data  <= b;
      rx_valid <= 1'b1;
   endtask
   task putx(input logic [7:0] b);
      if (esc && (b == 8'h7E || b == 8'h7D || b == 8'h11 || b == 8'h13))
      begin
         put(8'h7D);
         put(b ^ 8'h20);
      end
      else put(b);
   endtask
   task send(input logic [7:0] f[$], input logic bad);
      logic [7:0] s;
      s = 8'h00;
      put(8'h7E);
      putx(8'h00);
      putx(8'(f.size()));
      foreach (f[i])
      begin
         putx(f[i]);
         s = s + f[i];
      end
      putx((8'hFF - s) ^ {7'h00, bad});
      @(posedge sys_clk);
      rx_valid <= 1'b0;
      rx_data  <= ~rx_data;
   endtask
endmodule // apch_host

// ===== test/tb_top.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// self-checking bench
// ---------------------------------------------------------------
module tb_top;
   localparam N = 4;
   logic        sys_clk, reset, mode, rx_valid, tx_valid, tx_ready, frame_error, err_seen;
   logic [7:0]  rx_data, tx_data, am[N], pm[N];
   logic        pv[N];
   logic [63:0] names;
   logic [31:0] act;
   int          failures, check_count, cyc;
   apch_handler #(.N_PARAM(N), .IW(2)) u_apch_handler (.sys_clk(sys_clk), .reset(reset), .rx_data(rx_data),
      .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .api_framing_mode_setting(mode), .cmd_names(names), .param_active(act), .frame_error(frame_error));
   apch_host u_apch_host (.sys_clk(sys_clk), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .esc(mode));
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (frame_error === 1'b1) err_seen <= 1'b1;
      if (cyc == 60000)
      begin
         failures++;
         conclude();
      end
   end
   task check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // k below N is a slot, N the apply command, above N an unknown name
   task automatic op(input logic [7:0] ty, input logic [7:0] id, input int k, input logic wr, input logic bad);
      logic [7:0] f[$], e[$], x[$], v, c0, c1, s;
      v  = 8'($urandom);
      c0 = k < N ? names[16*k+8 +: 8] : (k == N ? 8'h41 : 8'h5A);
      c1 = k < N ? names[16*k +: 8] : (k == N ? 8'h43 : 8'h5A);
      f  = {ty, id, c0, c1};
      if (wr) f.push_back(v);
      err_seen <= 1'b0;
      u_apch_host.send(f, bad);
      if (!bad && (ty == 8'h08 || ty == 8'h09))
      begin
         for (int i = 0; i < N; i++) if (pv[i] && (ty == 8'h08 || k == N)) {am[i], pv[i]} = {pm[i], 1'b0};
         if (wr && k < N && ty == 8'h08) am[k] = v;
         if (wr && k < N && ty == 8'h09) {pm[k], pv[k]} = {v, 1'b1};
         if (id != 8'h00) e = {8'h88, id, c0, c1, 8'(k > N)};
         if (id != 8'h00 && !wr && k < N) e.push_back(am[k]);
      end
      s = 8'h00;
      foreach (e[i]) s = s + e[i];
      if (e.size() > 0) x = {8'h7E, 8'h00, 8'(e.size()), e, 8'hFF - s};
      for (int i = 0; i < 400 && u_apch_host.rq.size() < x.size(); i++) @(posedge sys_clk);
      repeat (20) @(posedge sys_clk);
      check("response length", x.size(), u_apch_host.rq.size());
      foreach (x[i]) if (i < u_apch_host.rq.size()) check("response byte", x[i], u_apch_host.rq[i]);
      check("frame error", bad, err_seen);
      check("active values", {am[3], am[2], am[1], am[0]}, act);
      u_apch_host.rq.delete();
   endtask
   initial
   begin
      {sys_clk, reset, mode, err_seen, failures, check_count, cyc} = {4'b0100, 96'h0};
      for (int i = 0; i < N; i++) {names[16*i +: 16], am[i], pm[i], pv[i]} = {8'h50 + 8'(i), 8'h30 + 8'(i), 17'h0};
      void'($urandom(32'h8B267301));
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      check("reset values", 32'h0, act);
      op(8'h08, 8'h01, 0, 1, 0);
      op(8'h09, 8'h02, 1, 1, 0);
      op(8'h09, 8'h03, 1, 1, 0);
      op(8'h09, 8'h04, 1, 0, 0);
      op(8'h09, 8'h00, N, 0, 0);
      op(8'h09, 8'h05, 2, 1, 0);
      op(8'h08, 8'h00, 3, 1, 0);
      op(8'h08, 8'h06, 2, 1, 1);
      op(8'h10, 8'h07, 0, 1, 0);
      op(8'h08, 8'h7E, N + 1, 0, 0);
      $display("test corners done");
      for (int m = 0; m < 2; m++)
      begin
         @(posedge sys_clk);
         mode <= m[0];
         repeat (40) op($urandom % 2 ? 8'h08 : 8'h09, 8'($urandom), $urandom % 5 == 4 ? N + 1 : $urandom % N,
            1'($urandom), $urandom % 8 == 0);
         $display("test random mode %0d done", m);
      end
      conclude();
   end
endmodule // tb_top
